// *** dv/can_far_model.sv ***
module can_far_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bench control
    input wire logic busHold,
    // bus side
    output logic bitTick = 1'b0,
    output logic canRxPin = 1'b1
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase = 2'h0;
    // four clocks per bit keeps the idle wait short but still well above one access
    always @(posedge clk) begin
        phase <= nrst ? phase + 2'h1 : 2'h0;
        bitTick <= nrst && phase == 2'h3;
        canRxPin <= ~busHold;
    end
endmodule : can_far_model

// *** dv/can_mode_control_tb_top.sv ***
module can_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import can_ctrl_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'h3;
    logic [31:0] readdata, q;
    logic waitrequest, canRxPin, canTxPin, canTxOe, canRxOwned, engineRx, bitTick, abortRequest, engineHalt;
    logic captureEvent, windowSelect, oe, own;
    logic engineTx = 1'b0, allAborted = 1'b0, chipIdle = 1'b0, messageReceived = 1'b0, busHold = 1'b0;
    logic invalidMessage, wakeActivity, fifoAlmostFull, rxOverflow, rxBufferDone, txBufferDone;
    logic txBusOff, txPassive, rxPassive, txWarning, rxWarning;
    logic [2:0] engineMode, dma;
    logic [5:0] dmaBufferCount, ev = 6'h00, fifoWritePointer = 6'h00, fifoReadPointer = 6'h00;
    logic [4:0] fifoStart, st, bi, es = 5'h00, dataCompareCount = 5'h00, matchedFilter = 5'h00;
    logic [15:0] bufferPending = 16'h0000;
    logic [2:0] modes [5] = '{3'h3, 3'h7, 3'h1, 3'h0, 3'h4};
    int pos [6] = '{0, 1, 2, 3, 6, 7};
    int codes [6] = '{'h40, 'h40, 'h43, 'h44, 'h42, 'h40};
    int sizes [7] = '{4, 6, 8, 12, 16, 24, 32};
    int nMismatch = 0;
    int totalChecks = 0;
    int t;
    assign {invalidMessage, wakeActivity, fifoAlmostFull, rxOverflow, rxBufferDone, txBufferDone} = ev;
    assign {txBusOff, txPassive, rxPassive, txWarning, rxWarning} = es;
    always #5 clk = ~clk;

    can_far_model FAR (.clk, .nrst, .busHold, .bitTick, .canRxPin);
    can_mode_control DUT (.clk, .nrst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
        .canRxPin, .canTxPin, .canTxOe, .canRxOwned, .engineTx, .engineRx, .bitTick, .allAborted, .abortRequest,
        .engineMode, .chipIdle, .engineHalt, .messageReceived, .captureEvent, .windowSelect, .dataCompareCount,
        .matchedFilter, .bufferPending, .fifoWritePointer, .fifoReadPointer, .dmaBufferCount, .fifoStart,
        .txBusOff, .txPassive, .rxPassive, .txWarning, .rxWarning, .invalidMessage, .wakeActivity,
        .fifoAlmostFull, .rxOverflow, .rxBufferDone, .txBufferDone);

    task automatic stop_test;
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        totalChecks++;
        if (g !== e) begin
            nMismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // request held until the edge that sees waitrequest low
    task automatic bus(input logic [4:0] a, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        read <= ~w;
        write <= w;
        writedata <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        if (n >= 50) nMismatch++;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        bus(a, 1'b0, 16'h0000);
        chk(q, e);
    endtask : rd

    task automatic wait_mode(input logic [2:0] m);
        t = 0;
        while (engineMode !== m && t < 300) begin
            @(posedge clk);
            t++;
        end
        chk({29'h0, engineMode}, {29'h0, m});
    endtask : wait_mode

    initial begin
        #300000;
        nMismatch++;
        stop_test();
    end

    initial begin
        void'($urandom(32'h67b60235));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(OFF_CTRL1, 32'h0480);
        rd(OFF_VEC, 32'h0040);
        rd(5'h18, 32'h0);
        chk({29'h0, canTxPin, canTxOe, canRxOwned}, 32'h4);
        $display("reset test done");
        busHold <= 1'b1;
        bus(OFF_CTRL1, 1'b1, 16'h02E9);
        repeat (100) @(posedge clk);
        rd(OFF_CTRL1, 32'h0289);
        busHold <= 1'b0;
        wait_mode(MODE_LOOPBACK);
        chk({31'h0, t >= 40}, 32'h1);
        @(posedge clk);
        chk({28'h0, canTxPin, canTxOe, canRxOwned, engineRx}, 32'h8);
        messageReceived <= 1'b1;
        @(posedge clk) messageReceived <= 1'b0;
        @(posedge clk);
        chk({31'h0, captureEvent}, 32'h1);
        $display("loopback test done");
        bus(OFF_CTRL1, 1'b1, 16'h3200);
        chipIdle <= 1'b1;
        messageReceived <= 1'b1;
        @(posedge clk) messageReceived <= 1'b0;
        repeat (2) @(posedge clk);
        chk({28'h0, abortRequest, engineHalt, windowSelect, captureEvent}, 32'hC);
        allAborted <= 1'b1;
        @(posedge clk) allAborted <= 1'b0;
        chipIdle <= 1'b0;
        rd(OFF_CTRL1, 32'h2240);
        chk({31'h0, engineHalt}, 32'h0);
        bus(OFF_CTRL1, 1'b1, 16'h0500);
        rd(OFF_CTRL1, 32'h0240);
        $display("abort test done");
        foreach (modes[i]) begin
            bus(OFF_CTRL1, 1'b1, {5'h00, modes[i], 8'h00});
            wait_mode(modes[i]);
            rd(OFF_CTRL1, {21'h0, modes[i], modes[i], 5'h00});
            oe = modes[i] == MODE_NORMAL || modes[i] == MODE_LISTEN_ALL;
            own = oe || modes[i] == MODE_LISTEN_ONLY;
            chk({29'h0, canTxPin, canTxOe, canRxOwned}, {29'h0, ~oe, oe, own});
            if (modes[i] == MODE_DISABLE) begin
                busHold <= 1'b1;
                repeat (3) @(posedge clk);
                busHold <= 1'b0;
                rd(OFF_INTF, 32'h0040);
                rd(OFF_VEC, 32'h0042);
                bus(OFF_INTF, 1'b1, 16'h0000);
            end
        end
        $display("mode test done");
        foreach (pos[i]) begin
            ev <= 6'h01 << i;
            @(posedge clk) ev <= 6'h00;
            rd(OFF_INTF, 32'h1 << pos[i]);
            rd(OFF_VEC, codes[i]);
            bus(OFF_INTF, 1'b1, 16'h0000);
            rd(OFF_INTF, 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            es <= 5'h01 << i;
            repeat (3) @(posedge clk);
            rd(OFF_INTF, {18'h0, es, es[1] | es[0], 8'h20});
            rd(OFF_VEC, 32'h0041);
            bus(OFF_INTF, 1'b1, 16'h0000);
            es <= 5'h00;
            @(posedge clk);
        end
        $display("flag test done");
        for (int k = 0; k < 4; k++) begin
            dma = 3'($urandom % 7);
            st = 5'($urandom);
            bi = 5'($urandom % 16);
            dataCompareCount <= 5'($urandom % 18);
            matchedFilter <= 5'($urandom % 16);
            fifoWritePointer <= 6'($urandom % 32);
            fifoReadPointer <= 6'($urandom % 32);
            bufferPending <= 16'h0001 << bi;
            bus(OFF_FCTRL, 1'b1, {dma, 8'h00, st});
            bus(OFF_FCTRL, 1'b1, {3'h7, 8'h00, st});
            rd(OFF_FCTRL, {16'h0, dma, 8'h00, st});
            chk({26'h0, dmaBufferCount}, 32'(sizes[dma]));
            chk({27'h0, fifoStart}, {27'h0, st});
            rd(OFF_CTRL2, {27'h0, dataCompareCount});
            rd(OFF_FIFO, {18'h0, fifoWritePointer, 2'h0, fifoReadPointer});
            rd(OFF_VEC, {19'h0, matchedFilter, 3'h0, bi});
        end
        $display("status test done");
        stop_test();
    end
endmodule : can_mode_control_tb_top

// *** rtl/can_ctrl_pkg.sv ***
package can_ctrl_pkg;
    // register byte offsets, one aligned 32-bit word each
    localparam logic [4:0] OFF_CTRL1 = 5'h00;
    localparam logic [4:0] OFF_CTRL2 = 5'h04;
    localparam logic [4:0] OFF_VEC = 5'h08;
    localparam logic [4:0] OFF_FCTRL = 5'h0C;
    localparam logic [4:0] OFF_FIFO = 5'h10;
    localparam logic [4:0] OFF_INTF = 5'h14;

    // module_control_one fields
    localparam int CTRL1_STOP_IDLE = 13;
    localparam int CTRL1_ABORT = 12;
    localparam int CTRL1_REQ_LSB = 8;
    localparam int CTRL1_CUR_LSB = 5;
    localparam int CTRL1_CAPTURE = 3;
    localparam int CTRL1_WINDOW = 0;

    // fifo_configuration and fifo_pointer_status fields
    localparam int FCTRL_DMA_LSB = 13;
    localparam int FCTRL_START_LSB = 0;
    localparam int FIFO_WRITE_LSB = 8;
    localparam int FIFO_READ_LSB = 0;

    // interrupt_code_vector and interrupt_flags fields
    localparam int VEC_FILTER_LSB = 8;
    localparam int VEC_CODE_LSB = 0;
    localparam int INTF_STATE_LSB = 8;
    localparam int FLAG_INVALID = 7;
    localparam int FLAG_WAKE = 6;
    localparam int FLAG_ERROR = 5;
    localparam int FLAG_FIFO = 3;
    localparam int FLAG_OVERFLOW = 2;
    localparam int FLAG_RXBUF = 1;
    localparam int FLAG_TXBUF = 0;
    localparam logic [7:0] FLAG_MASK = 8'hEF;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_DISABLE = 3'b001,
        MODE_LOOPBACK = 3'b010,
        MODE_LISTEN_ONLY = 3'b011,
        MODE_CONFIG = 3'b100,
        MODE_RESERVED_A = 3'b101,
        MODE_RESERVED_B = 3'b110,
        MODE_LISTEN_ALL = 3'b111
    } mode_type;

    localparam logic [6:0] CODE_NONE = 7'h40;
    localparam logic [6:0] CODE_ERROR = 7'h41;
    localparam logic [6:0] CODE_WAKE = 7'h42;
    localparam logic [6:0] CODE_OVERFLOW = 7'h43;
    localparam logic [6:0] CODE_FIFO = 7'h44;

    localparam logic [2:0] DMA_SIZE_RESERVED = 3'h7;
    localparam logic [4:0] FILTER_HIT_RESET = 5'h00;
    localparam logic [3:0] IDLE_BITS = 4'hB;

    function automatic logic [5:0] dma_buffers(input logic [2:0] sel);
        case (sel)
            3'h0: dma_buffers = 6'h04;
            3'h1: dma_buffers = 6'h06;
            3'h2: dma_buffers = 6'h08;
            3'h3: dma_buffers = 6'h0C;
            3'h4: dma_buffers = 6'h10;
            3'h5: dma_buffers = 6'h18;
            default: dma_buffers = 6'h20;
        endcase
    endfunction : dma_buffers
endpackage : can_ctrl_pkg

// *** rtl/can_idle_detect.sv ***
module can_idle_detect (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bit stream
    input wire logic bitTick,
    input wire logic rxLevel,
    // result
    output logic busIdle
);
    import can_ctrl_pkg::*;

    typedef struct packed {
        logic [3:0] count;
        logic idle;
    } idle_state_type;

    idle_state_type state, next_state;

    always_comb begin
        next_state = state;
        if (bitTick) begin
            if (!rxLevel) begin
                next_state.count = 4'h0;
                next_state.idle = 1'b0;
            end else if (state.count != IDLE_BITS) begin
                next_state.count = state.count + 4'h1;
            end
            if (rxLevel && (state.count >= IDLE_BITS - 4'h1)) begin
                next_state.idle = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= '{count: 4'h0, idle: 1'b0};
        end else begin
            state <= next_state;
        end
    end

    assign busIdle = state.idle;
endmodule : can_idle_detect

// *** rtl/can_irq_encode.sv ***
module can_irq_encode (
    // pending flags
    input wire logic errorPending,
    input wire logic wakePending,
    input wire logic overflowPending,
    input wire logic fifoPending,
    input wire logic [15:0] bufferPending,
    // code
    output logic [6:0] code
);
    import can_ctrl_pkg::*;

    // fixed priority: module events first, then lowest buffer index
    always_comb begin
        code = CODE_NONE;
        for (int i = 15; i >= 0; i--) begin
            if (bufferPending[i]) begin
                code = 7'(i);
            end
        end
        if (fifoPending) begin
            code = CODE_FIFO;
        end
        if (overflowPending) begin
            code = CODE_OVERFLOW;
        end
        if (wakePending) begin
            code = CODE_WAKE;
        end
        if (errorPending) begin
            code = CODE_ERROR;
        end
    end
endmodule : can_irq_encode

// *** rtl/can_mode_control.sv ***
// Our own choices: the address map and the Avalon-MM register port.
module can_mode_control (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // bus pins
    input wire logic canRxPin,
    output logic canTxPin,
    output logic canTxOe,
    output logic canRxOwned,
    // protocol engine
    input wire logic engineTx,
    output logic engineRx,
    input wire logic bitTick,
    input wire logic allAborted,
    output logic abortRequest,
    output logic [2:0] engineMode,
    // chip power state
    input wire logic chipIdle,
    output logic engineHalt,
    // capture and window
    input wire logic messageReceived,
    output logic captureEvent,
    output logic windowSelect,
    // filter and buffer status
    input wire logic [4:0] dataCompareCount,
    input wire logic [4:0] matchedFilter,
    input wire logic [15:0] bufferPending,
    input wire logic [5:0] fifoWritePointer,
    input wire logic [5:0] fifoReadPointer,
    output logic [5:0] dmaBufferCount,
    output logic [4:0] fifoStart,
    // error states and events
    input wire logic txBusOff,
    input wire logic txPassive,
    input wire logic rxPassive,
    input wire logic txWarning,
    input wire logic rxWarning,
    input wire logic invalidMessage,
    input wire logic wakeActivity,
    input wire logic fifoAlmostFull,
    input wire logic rxOverflow,
    input wire logic rxBufferDone,
    input wire logic txBufferDone
);
    import can_ctrl_pkg::*;

    typedef struct packed {
        logic waitReq;
        logic [31:0] rdata;
        logic stopIdle;
        logic abortAll;
        logic [2:0] modeRequest;
        logic [2:0] currentMode;
        logic captureEnable;
        logic window;
        logic [4:0] compareCount;
        logic [4:0] filterHit;
        logic [6:0] irqCode;
        logic [2:0] dmaSelect;
        logic [5:0] dmaCount;
        logic [4:0] startBuffer;
        logic [5:0] writePointer;
        logic [5:0] readPointer;
        logic [5:0] errState;
        logic [7:0] flags;
        logic txPin;
        logic txOe;
        logic rxOwned;
        logic rxToEngine;
        logic halt;
        logic capture;
        logic prevRx;
    } ctrl_state_type;

    ctrl_state_type state, next_state;
    logic busIdle;
    logic [6:0] codeNow;
    logic [5:0] errNow;
    logic [7:0] flagSet;
    logic request;
    logic doWrite;
    logic lowLane;
    logic highLane;
    logic loopback;
    logic pinsActive;

    can_idle_detect idleDetect (
        .clk(clk),
        .nrst(nrst),
        .bitTick(bitTick),
        .rxLevel(canRxPin),
        .busIdle(busIdle)
    );

    can_irq_encode irqEncode (
        .errorPending(state.flags[FLAG_ERROR]),
        .wakePending(state.flags[FLAG_WAKE]),
        .overflowPending(state.flags[FLAG_OVERFLOW]),
        .fifoPending(state.flags[FLAG_FIFO]),
        .bufferPending(bufferPending),
        .code(codeNow)
    );

    assign request = read | write;
    // a write lands only at the edge where waitrequest is seen low
    assign doWrite = write & ~state.waitReq;
    assign lowLane = byteenable[0];
    assign highLane = byteenable[1];
    assign loopback = state.currentMode == MODE_LOOPBACK;
    assign pinsActive = (state.currentMode == MODE_NORMAL) || (state.currentMode == MODE_LISTEN_ALL);
    // combined warning is derived so it can never disagree with its sources
    assign errNow = {txBusOff, txPassive, rxPassive, txWarning, rxWarning, txWarning | rxWarning};

    always_comb begin
        flagSet = 8'h00;
        flagSet[FLAG_INVALID] = invalidMessage;
        // wake-up still seen on the raw pin while disabled
        flagSet[FLAG_WAKE] = wakeActivity |
            ((state.currentMode == MODE_DISABLE) && state.prevRx && !canRxPin);
        flagSet[FLAG_ERROR] = |(errNow & ~state.errState);
        flagSet[FLAG_FIFO] = fifoAlmostFull;
        flagSet[FLAG_OVERFLOW] = rxOverflow;
        flagSet[FLAG_RXBUF] = rxBufferDone;
        flagSet[FLAG_TXBUF] = txBufferDone;
    end

    always_comb begin
        next_state = state;
        next_state.waitReq = ~(request & state.waitReq);
        next_state.prevRx = canRxPin;
        next_state.errState = errNow;
        next_state.compareCount = dataCompareCount;
        next_state.filterHit = matchedFilter;
        next_state.irqCode = codeNow;
        next_state.writePointer = fifoWritePointer;
        next_state.readPointer = fifoReadPointer;
        // read data captured one edge early so it stands while waitrequest is low
        next_state.rdata = 32'h0000_0000;
        if (read && state.waitReq) begin
            if (address == OFF_CTRL1) begin
                next_state.rdata[CTRL1_STOP_IDLE] = state.stopIdle;
                next_state.rdata[CTRL1_ABORT] = state.abortAll;
                next_state.rdata[CTRL1_REQ_LSB +: 3] = state.modeRequest;
                next_state.rdata[CTRL1_CUR_LSB +: 3] = state.currentMode;
                next_state.rdata[CTRL1_CAPTURE] = state.captureEnable;
                next_state.rdata[CTRL1_WINDOW] = state.window;
            end else if (address == OFF_CTRL2) begin
                next_state.rdata[4:0] = state.compareCount;
            end else if (address == OFF_VEC) begin
                next_state.rdata[VEC_FILTER_LSB +: 5] = state.filterHit;
                next_state.rdata[VEC_CODE_LSB +: 7] = state.irqCode;
            end else if (address == OFF_FCTRL) begin
                next_state.rdata[FCTRL_DMA_LSB +: 3] = state.dmaSelect;
                next_state.rdata[FCTRL_START_LSB +: 5] = state.startBuffer;
            end else if (address == OFF_FIFO) begin
                next_state.rdata[FIFO_WRITE_LSB +: 6] = state.writePointer;
                next_state.rdata[FIFO_READ_LSB +: 6] = state.readPointer;
            end else if (address == OFF_INTF) begin
                next_state.rdata[INTF_STATE_LSB +: 6] = state.errState;
                next_state.rdata[7:0] = state.flags & FLAG_MASK;
            end
        end
        // hardware clear of abort comes first so a fresh software set wins
        if (allAborted) begin
            next_state.abortAll = 1'b0;
        end
        // only writable fields are touched; the rest is ignored
        if (doWrite) begin
            if (address == OFF_CTRL1) begin
                if (highLane) begin
                    next_state.stopIdle = writedata[CTRL1_STOP_IDLE];
                    if (writedata[CTRL1_ABORT]) begin
                        next_state.abortAll = 1'b1;
                    end
                    // reserved codes are dropped rather than stored
                    if (writedata[CTRL1_REQ_LSB +: 3] != MODE_RESERVED_A &&
                        writedata[CTRL1_REQ_LSB +: 3] != MODE_RESERVED_B) begin
                        next_state.modeRequest = writedata[CTRL1_REQ_LSB +: 3];
                    end
                end
                if (lowLane) begin
                    next_state.captureEnable = writedata[CTRL1_CAPTURE];
                    next_state.window = writedata[CTRL1_WINDOW];
                end
            end else if (address == OFF_FCTRL) begin
                if (highLane && writedata[FCTRL_DMA_LSB +: 3] != DMA_SIZE_RESERVED) begin
                    next_state.dmaSelect = writedata[FCTRL_DMA_LSB +: 3];
                end
                if (lowLane) begin
                    next_state.startBuffer = writedata[FCTRL_START_LSB +: 5];
                end
            end
        end
        // flags clear by writing zero; a set in the same cycle still wins
        next_state.flags = state.flags;
        if (doWrite && address == OFF_INTF && lowLane) begin
            next_state.flags = state.flags & writedata[7:0];
        end
        next_state.flags = (next_state.flags | flagSet) & FLAG_MASK;
        // mode switch waits for an idle bus
        if (busIdle && state.currentMode != state.modeRequest) begin
            next_state.currentMode = state.modeRequest;
        end
        // size decode registered so the output comes from a flip-flop
        next_state.dmaCount = dma_buffers(next_state.dmaSelect);
        // pin ownership and loopback path
        next_state.txOe = pinsActive;
        next_state.rxOwned = pinsActive || (state.currentMode == MODE_LISTEN_ONLY);
        next_state.txPin = pinsActive ? engineTx : 1'b1;
        next_state.rxToEngine = loopback ? engineTx : canRxPin;
        next_state.halt = state.stopIdle & chipIdle;
        next_state.capture = state.captureEnable & messageReceived;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= '0;
            state.waitReq <= 1'b1;
            state.modeRequest <= MODE_CONFIG;
            state.currentMode <= MODE_CONFIG;
            state.irqCode <= CODE_NONE;
            state.filterHit <= FILTER_HIT_RESET;
            state.dmaCount <= dma_buffers(3'h0);
            state.txPin <= 1'b1;
            state.rxToEngine <= 1'b1;
            state.prevRx <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign readdata = state.rdata;
    assign waitrequest = state.waitReq;
    assign canTxPin = state.txPin;
    assign canTxOe = state.txOe;
    assign canRxOwned = state.rxOwned;
    assign engineRx = state.rxToEngine;
    assign abortRequest = state.abortAll;
    assign engineMode = state.currentMode;
    assign engineHalt = state.halt;
    assign captureEvent = state.capture;
    assign windowSelect = state.window;
    assign dmaBufferCount = state.dmaCount;
    assign fifoStart = state.startBuffer;

    // checks
    mode_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (state.currentMode != $past(state.currentMode)) |-> $past(busIdle))
        else $error("mode changed on a busy bus");
    mode_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        (busIdle && state.currentMode != state.modeRequest) |=> (state.currentMode == $past(state.modeRequest)))
        else $error("current mode did not follow request");
    loop_path_a: assert property (@(posedge clk) disable iff (!nrst)
        (loopback && engineMode == MODE_LOOPBACK) |=> (engineRx == $past(engineTx)))
        else $error("loopback path broken");
    loop_pins_a: assert property (@(posedge clk) disable iff (!nrst)
        loopback |=> (!canTxOe && !canRxOwned))
        else $error("pins held in loopback");
    halt_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        (state.stopIdle && chipIdle) |=> engineHalt)
        else $error("no halt in idle");
    abort_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        (allAborted && !doWrite) |=> !abortRequest)
        else $error("abort not cleared");
    capture_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        captureEvent |-> $past(messageReceived && state.captureEnable))
        else $error("capture without enable");
    set_wins_a: assert property (@(posedge clk) disable iff (!nrst)
        rxOverflow |=> state.flags[FLAG_OVERFLOW])
        else $error("overflow flag lost");
    reserved_mode_a: assert property (@(posedge clk) disable iff (!nrst)
        (state.modeRequest != MODE_RESERVED_A) && (state.modeRequest != MODE_RESERVED_B))
        else $error("reserved mode stored");
    bus_answer_a: assert property (@(posedge clk) disable iff (!nrst)
        (request && waitrequest) |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");
    error_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        (txBusOff && !state.errState[5]) |=> state.flags[FLAG_ERROR])
        else $error("error flag not set");
    code_none_a: assert property (@(posedge clk) disable iff (!nrst)
        (state.flags[5] == 1'b0 && state.flags[6] == 1'b0 && state.flags[3:2] == 2'b00 && bufferPending == 16'h0000)
        |=> state.irqCode == CODE_NONE)
        else $error("spurious interrupt code");
    dma_size_a: assert property (@(posedge clk) disable iff (!nrst)
        (state.dmaSelect != DMA_SIZE_RESERVED) && (dmaBufferCount == dma_buffers(state.dmaSelect)))
        else $error("dma size wrong");
    no_halt_a: assert property (@(posedge clk) disable iff (!nrst)
        !state.stopIdle |=> !engineHalt)
        else $error("halt while stop bit clear");
    window_write_a: assert property (@(posedge clk) disable iff (!nrst)
        (doWrite && address == OFF_CTRL1 && lowLane) |=> (windowSelect == $past(writedata[CTRL1_WINDOW])))
        else $error("window bit not written");
    flag_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        (doWrite && address == OFF_INTF && lowLane && !writedata[FLAG_TXBUF] && !txBufferDone)
        |=> !state.flags[FLAG_TXBUF])
        else $error("flag not cleared");
    unused_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        !state.flags[4])
        else $error("unimplemented flag set");
    pins_free_a: assert property (@(posedge clk) disable iff (!nrst)
        !pinsActive |=> canTxPin)
        else $error("tx pin driven low while released");
    capture_off_a: assert property (@(posedge clk) disable iff (!nrst)
        !state.captureEnable |=> !captureEvent)
        else $error("capture while disabled");
    fifo_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        fifoAlmostFull |=> state.flags[FLAG_FIFO])
        else $error("fifo flag lost");
    read_high_a: assert property (@(posedge clk) disable iff (!nrst)
        readdata[31:16] == 16'h0000)
        else $error("upper read bits set");

    mode_switch_c: cover property (@(posedge clk) disable iff (!nrst)
        $past(state.currentMode) == MODE_CONFIG && state.currentMode == MODE_NORMAL);
    loopback_c: cover property (@(posedge clk) disable iff (!nrst) loopback && engineTx == 1'b0);
    abort_c: cover property (@(posedge clk) disable iff (!nrst) abortRequest ##1 !abortRequest);
    flag_clear_c: cover property (@(posedge clk) disable iff (!nrst) doWrite && address == OFF_INTF);
    disable_wake_c: cover property (@(posedge clk) disable iff (!nrst)
        state.currentMode == MODE_DISABLE && flagSet[FLAG_WAKE]);
endmodule : can_mode_control
